// File: include/pwm_regs_pkg.sv
// Register map, field layout and timing constants of the two-channel modulator
package pwm_regs_pkg;
    // Channel register set, byte offsets within one channel
    localparam logic [7:0] OFS_PULSE_CONTROL = 8'h00;
    localparam logic [7:0] OFS_DUTY_HIGH = 8'h04;
    localparam logic [7:0] OFS_DUTY_LOW = 8'h08;
    localparam logic [7:0] CHANNEL_STRIDE = 8'h10;
    // Shared time base registers
    localparam logic [7:0] OFS_PERIOD = 8'h20;
    localparam logic [7:0] OFS_TIMER_CONTROL = 8'h24;
    localparam logic [7:0] OFS_TIMER_COUNT = 8'h28;

    localparam int NUM_CHANNELS = 2;
    localparam int DUTY_W = 10;
    localparam int TIMER_W = 8;
    localparam int SUB_W = 6;

    // Pulse control fields
    localparam int BIT_ENABLE = 7;
    localparam int BIT_READBACK = 5;
    localparam int BIT_POLARITY = 4;
    // Duty low register holds the two least significant bits here
    localparam int DUTY_LOW_MSB = 7;
    localparam int DUTY_LOW_LSB = 6;
    // Timer control fields
    localparam int BIT_TIMER_ON = 0;
    localparam int PRESCALE_LSB = 4;
    localparam int PRESCALE_MSB = 5;

    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] PERIOD_RESET = 8'hFF;
    localparam logic [7:0] TIMER_RESET = 8'h00;

    // Prescale codes 1, 4 and 16: one timer tick per four clocks times the prescale
    typedef enum logic [1:0] {
        PRESCALE_1,
        PRESCALE_4,
        PRESCALE_16,
        PRESCALE_16B
    } prescale_type;

    localparam logic [SUB_W-1:0] SUB_LAST_1 = 6'h03;
    localparam logic [SUB_W-1:0] SUB_LAST_4 = 6'h0F;
    localparam logic [SUB_W-1:0] SUB_LAST_16 = 6'h3F;
endpackage : pwm_regs_pkg

// File: core/pwm_channel.sv
// One modulator channel: buffered duty, comparison against the time base, output drive
`timescale 1ns/1ps
module pwm_channel
    import pwm_regs_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic enable,
    input wire logic polarity,
    input wire logic [DUTY_W-1:0] duty_buffer,
    input wire logic reload,
    input wire logic [DUTY_W-1:0] time_base,
    output logic out_level
);
    logic [DUTY_W-1:0] duty_q;
    logic [DUTY_W-1:0] duty_d;
    logic active_q;
    logic active_d;
    logic out_q;
    logic out_d;

    // Duty only changes at a period end, so software writes never cut a pulse short
    always_comb begin
        duty_d = duty_q;
        active_d = active_q;
        if (reload) begin
            duty_d = duty_buffer;
            active_d = (duty_buffer != '0);
        end else if (time_base >= duty_q) begin
            active_d = 1'b0;
        end
        // Disabled channel shows its inactive level, set by polarity
        out_d = enable ? (active_q ^ polarity) : polarity;
    end

    // Duty latch has no reset: it follows the buffer at the first period end anyway
    always_ff @(posedge clk) begin
        duty_q <= duty_d;
    end

    // Pulse state and registered output
    always_ff @(posedge clk) begin
        if (rst) begin
            active_q <= 1'b0;
            out_q <= 1'b0;
        end else begin
            active_q <= active_d;
            out_q <= out_d;
        end
    end

    assign out_level = out_q;
endmodule : pwm_channel

// File: core/pulse_width_control_regs.sv
// Wishbone register set, shared time base and two modulator channels
`timescale 1ns/1ps
// What this block does
// - Control bit 7 enables the modulator when one, disables it when zero.
// - Control bit 5 reads back the live output level; writes ignored.
// - Control bit 4 set makes output active-low, clear makes it active-high.
// - Duty high register holds duty bits 9 to 2 in positions 7 to 0.
// - Duty low register holds duty bits 1 and 0 in positions 7 and 6.
// - Unimplemented bits read zero and ignore writes.
// - Control clears on every reset; duty bits keep their value across reset.
// - Written duty is buffered and applied only at the period match.
// - After period match: clear timer, latch duty, set output unless duty zero.
// - Disabled modulator holds the inactive level chosen by polarity.
// - Duty compares against timer count extended by two clock or prescaler bits.
module pulse_width_control_regs
    import pwm_regs_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RESET,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    output logic [NUM_CHANNELS-1:0] PWM_OUT
);
    // Byte address of a register inside a channel
    function automatic logic [7:0] chan_addr(input int ch, input logic [7:0] ofs);
        chan_addr = 8'(ch * CHANNEL_STRIDE) + ofs;
    endfunction : chan_addr

    // Last sub-count value for the selected prescale
    function automatic logic [SUB_W-1:0] sub_last(input prescale_type ps);
        case (ps)
            PRESCALE_1: sub_last = SUB_LAST_1;
            PRESCALE_4: sub_last = SUB_LAST_4;
            default: sub_last = SUB_LAST_16;
        endcase
    endfunction : sub_last

    // Two extension bits: the top two bits of the running sub-count
    function automatic logic [1:0] sub_phase(input prescale_type ps, input logic [SUB_W-1:0] s);
        case (ps)
            PRESCALE_1: sub_phase = s[1:0];
            PRESCALE_4: sub_phase = s[3:2];
            default: sub_phase = s[5:4];
        endcase
    endfunction : sub_phase

    logic [NUM_CHANNELS-1:0] enable_q;
    logic [NUM_CHANNELS-1:0] enable_d;
    logic [NUM_CHANNELS-1:0] polarity_q;
    logic [NUM_CHANNELS-1:0] polarity_d;
    logic [7:0] duty_high_q [NUM_CHANNELS];
    logic [7:0] duty_high_d [NUM_CHANNELS];
    logic [1:0] duty_low_q [NUM_CHANNELS];
    logic [1:0] duty_low_d [NUM_CHANNELS];
    logic [TIMER_W-1:0] period_q;
    logic [TIMER_W-1:0] period_d;
    logic timer_on_q;
    logic timer_on_d;
    prescale_type prescale_q;
    prescale_type prescale_d;
    logic [TIMER_W-1:0] timer_q;
    logic [TIMER_W-1:0] timer_d;
    logic [SUB_W-1:0] sub_q;
    logic [SUB_W-1:0] sub_d;
    logic reload_q;
    logic reload_d;
    logic ack_q;
    logic ack_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [NUM_CHANNELS-1:0] out_level;
    logic [DUTY_W-1:0] time_base;
    logic wr_en;
    logic req;

    // Writes land on the edge where the master sees ack, byte lane 0 only
    assign req = WB_CYC_I && WB_STB_I;
    assign wr_en = req && ack_q && WB_WE_I && WB_SEL_I[0];

    // Bus answer: ack one cycle after the request, dropped the cycle after
    always_comb begin
        ack_d = req && !ack_q;
        rdata_d = rdata_q;
        if (req && !ack_q) begin
            rdata_d = '0; // Unmapped addresses read zero and still ack
            for (int ch = 0; ch < NUM_CHANNELS; ch++) begin
                if (WB_ADR_I == chan_addr(ch, OFS_PULSE_CONTROL)) begin
                    rdata_d[BIT_ENABLE] = enable_q[ch];
                    rdata_d[BIT_READBACK] = out_level[ch];
                    rdata_d[BIT_POLARITY] = polarity_q[ch];
                end else if (WB_ADR_I == chan_addr(ch, OFS_DUTY_HIGH)) begin
                    rdata_d[7:0] = duty_high_q[ch];
                end else if (WB_ADR_I == chan_addr(ch, OFS_DUTY_LOW)) begin
                    rdata_d[DUTY_LOW_MSB:DUTY_LOW_LSB] = duty_low_q[ch];
                end
            end
            if (WB_ADR_I == OFS_PERIOD) begin
                rdata_d[TIMER_W-1:0] = period_q;
            end else if (WB_ADR_I == OFS_TIMER_CONTROL) begin
                rdata_d[BIT_TIMER_ON] = timer_on_q;
                rdata_d[PRESCALE_MSB:PRESCALE_LSB] = prescale_q;
            end else if (WB_ADR_I == OFS_TIMER_COUNT) begin
                rdata_d[TIMER_W-1:0] = timer_q;
            end
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            ack_q <= 1'b0;
            rdata_q <= '0;
        end else begin
            ack_q <= ack_d;
            rdata_q <= rdata_d;
        end
    end

    // Control and time base configuration writes
    always_comb begin
        enable_d = enable_q;
        polarity_d = polarity_q;
        period_d = period_q;
        timer_on_d = timer_on_q;
        prescale_d = prescale_q;
        if (wr_en) begin
            for (int ch = 0; ch < NUM_CHANNELS; ch++) begin
                if (WB_ADR_I == chan_addr(ch, OFS_PULSE_CONTROL)) begin
                    enable_d[ch] = WB_DAT_I[BIT_ENABLE];
                    polarity_d[ch] = WB_DAT_I[BIT_POLARITY];
                end
            end
            if (WB_ADR_I == OFS_PERIOD) begin
                period_d = WB_DAT_I[TIMER_W-1:0];
            end else if (WB_ADR_I == OFS_TIMER_CONTROL) begin
                timer_on_d = WB_DAT_I[BIT_TIMER_ON];
                prescale_d = prescale_type'(WB_DAT_I[PRESCALE_MSB:PRESCALE_LSB]);
            end
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            enable_q <= '0;
            polarity_q <= '0;
            period_q <= PERIOD_RESET;
            timer_on_q <= 1'b0;
            prescale_q <= PRESCALE_1;
        end else begin
            enable_q <= enable_d;
            polarity_q <= polarity_d;
            period_q <= period_d;
            timer_on_q <= timer_on_d;
            prescale_q <= prescale_d;
        end
    end

    // Duty buffers, split left-justified over the high and low registers
    always_comb begin
        for (int ch = 0; ch < NUM_CHANNELS; ch++) begin
            duty_high_d[ch] = duty_high_q[ch];
            duty_low_d[ch] = duty_low_q[ch];
            if (wr_en && WB_ADR_I == chan_addr(ch, OFS_DUTY_HIGH)) begin
                duty_high_d[ch] = WB_DAT_I[7:0];
            end
            if (wr_en && WB_ADR_I == chan_addr(ch, OFS_DUTY_LOW)) begin
                duty_low_d[ch] = WB_DAT_I[DUTY_LOW_MSB:DUTY_LOW_LSB];
            end
        end
    end

    // No reset on purpose: duty survives a reset and starts unknown at power-up
    always_ff @(posedge REF_CLK) begin
        duty_high_q <= duty_high_d;
        duty_low_q <= duty_low_d;
    end

    // Time base: sub-count of four clocks times prescale, then the 8-bit timer
    always_comb begin
        sub_d = sub_q;
        timer_d = timer_q;
        reload_d = 1'b0;
        if (timer_on_q) begin
            if (sub_q >= sub_last(prescale_q)) begin
                sub_d = '0;
                if (timer_q == period_q) begin
                    timer_d = '0;
                    reload_d = 1'b1;
                end else begin
                    timer_d = timer_q + 8'h01;
                end
            end else begin
                sub_d = sub_q + 6'h01;
            end
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            sub_q <= '0;
            timer_q <= TIMER_RESET;
            reload_q <= 1'b0;
        end else begin
            sub_q <= sub_d;
            timer_q <= timer_d;
            reload_q <= reload_d;
        end
    end

    // Compared value is the timer count with two finer phase bits below it
    assign time_base = {timer_q, sub_phase(prescale_q, sub_q)};

    // Each channel runs on its own registers against the shared time base
    for (genvar ch = 0; ch < NUM_CHANNELS; ch++) begin : g_channel
        pwm_channel u_channel (
            .clk(REF_CLK),
            .rst(RESET),
            .enable(enable_q[ch]),
            .polarity(polarity_q[ch]),
            .duty_buffer({duty_high_q[ch], duty_low_q[ch]}),
            .reload(reload_q),
            .time_base(time_base),
            .out_level(out_level[ch])
        );
    end

    assign PWM_OUT = out_level;
    assign WB_ACK_O = ack_q;
    assign WB_DAT_O = rdata_q;
endmodule : pulse_width_control_regs

// File: verif/pwm_chk.sv
// Checker of bus timing, read field zeros and idle output level
`timescale 1ns/1ps
module pwm_chk
    import pwm_regs_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RESET,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic WB_ACK_O,
    input wire logic [NUM_CHANNELS-1:0] PWM_OUT
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (RESET);
    logic en_q, en_d, pol_q, pol_d;
    logic [3:0] quiet_q, quiet_d;
    logic wr0, rd_ack;
    assign wr0 = WB_ACK_O & WB_WE_I & WB_SEL_I[0] & (WB_ADR_I == OFS_PULSE_CONTROL);
    assign rd_ack = WB_ACK_O & !WB_WE_I;
    // Shadow of channel 0 control; output needs a few clocks to follow a write
    always_comb begin
        en_d = en_q;
        pol_d = pol_q;
        quiet_d = (quiet_q == 4'hF) ? quiet_q : quiet_q + 4'h1;
        if (wr0) begin
            en_d = WB_DAT_I[7];
            pol_d = WB_DAT_I[4];
            quiet_d = 4'h0;
        end
    end
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            en_q <= 1'b0;
            pol_q <= 1'b0;
            quiet_q <= 4'h0;
        end else begin
            en_q <= en_d;
            pol_q <= pol_d;
            quiet_q <= quiet_d;
        end
    end
    sequence bus_req;
        WB_CYC_I && WB_STB_I && !WB_ACK_O;
    endsequence
    sequence ctl0_read;
        rd_ack && WB_ADR_I == OFS_PULSE_CONTROL;
    endsequence
    ack_timing_a: assert property (bus_req |=> WB_ACK_O)
        else $error("ack missing one cycle after request");
    ack_pulse_a: assert property ($rose(WB_ACK_O) |=> !WB_ACK_O)
        else $error("ack longer than one cycle");
    reset_quiet_a: assert property (disable iff (1'b0) $fell(RESET) |-> !WB_ACK_O && PWM_OUT == '0)
        else $error("outputs not quiet after reset");
    high_zero_a: assert property (WB_ACK_O |-> WB_DAT_O[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    ctl_unused_a: assert property (rd_ack && (WB_ADR_I & 8'hEF) == OFS_PULSE_CONTROL |-> WB_DAT_O[6] == 1'b0 && WB_DAT_O[3:0] == 4'h0)
        else $error("control unused bits not zero");
    low_unused_a: assert property (rd_ack && (WB_ADR_I & 8'hEF) == OFS_DUTY_LOW |-> WB_DAT_O[5:0] == 6'h00)
        else $error("duty low unused bits not zero");
    unmapped_zero_a: assert property (rd_ack && WB_ADR_I == 8'h0C |-> WB_DAT_O == 32'h00000000)
        else $error("unmapped read not zero");
    idle_level_a: assert property (!en_q && quiet_q > 4'h3 |-> PWM_OUT[0] == pol_q)
        else $error("disabled output not at polarity level");
    readback_idle_a: assert property (ctl0_read and (!en_q && quiet_q > 4'h4) |-> WB_DAT_O[5] == pol_q)
        else $error("readback bit differs from idle level");
endmodule : pwm_chk

// File: verif/load_model.sv
// Load on one modulator output: counts clocks spent high in a window
`timescale 1ns/1ps
module load_model (
    input wire logic clk,
    input wire logic clear,
    input wire logic level,
    output logic [7:0] highs_q
);
    // A pure sink: the load never drives back, so only the count is kept
    always_ff @(posedge clk) begin
        if (clear) begin
            highs_q <= 8'h00;
        end else if (level) begin
            highs_q <= highs_q + 8'h01;
        end
    end
endmodule : load_model

// File: verif/tb.sv
// Testbench of the two-channel modulator register set
`timescale 1ns/1ps
module tb;
    import pwm_regs_pkg::*;
    logic REF_CLK = 1'b0, RESET = 1'b1, WB_CYC_I = 1'b0, WB_STB_I = 1'b0, WB_WE_I = 1'b0;
    logic [7:0] WB_ADR_I = 8'h00;
    logic [3:0] WB_SEL_I = 4'h0;
    logic [31:0] WB_DAT_I = 32'h0, WB_DAT_O;
    logic WB_ACK_O, clear = 1'b0;
    logic [1:0] PWM_OUT;
    logic [7:0] rd, hi0, hi1;
    int miscompares = 0, checked = 0, cycles = 0;
    pulse_width_control_regs i_pulse_width_control_regs (.REF_CLK(REF_CLK), .RESET(RESET),
        .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
        .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
        .PWM_OUT(PWM_OUT));
    load_model i_load0 (.clk(REF_CLK), .clear(clear), .level(PWM_OUT[0]), .highs_q(hi0));
    load_model i_load1 (.clk(REF_CLK), .clear(clear), .level(PWM_OUT[1]), .highs_q(hi1));
    initial begin
        forever #2.5 REF_CLK = ~REF_CLK;
    end
    task automatic print_verdict();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : print_verdict
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Classic cycle: hold everything until ack is seen, take data there
    task automatic bus(input logic we, input logic [7:0] adr, input logic [7:0] wd);
        @(posedge REF_CLK);
        WB_CYC_I <= 1'b1;
        WB_STB_I <= 1'b1;
        WB_WE_I <= we;
        WB_ADR_I <= adr;
        WB_SEL_I <= 4'hF;
        WB_DAT_I <= {24'h000000, wd};
        // Ack and data are read at the rising edge, before that edge updates them
        do @(posedge REF_CLK); while (WB_ACK_O !== 1'b1);
        rd = WB_DAT_O[7:0];
        WB_CYC_I <= 1'b0;
        WB_STB_I <= 1'b0;
    endtask : bus
    task automatic rdc(input string what, input logic [7:0] adr, input logic [7:0] exp);
        bus(1'b0, adr, 8'h00);
        chk(what, exp, rd);
    endtask : rdc
    // Let two slow periods pass so new duty is latched, then count 64 clocks
    task automatic window(input logic [7:0] e0, input logic [7:0] e1);
        repeat (140) @(posedge REF_CLK);
        clear <= 1'b1;
        @(posedge REF_CLK);
        clear <= 1'b0;
        repeat (64) @(posedge REF_CLK);
        @(negedge REF_CLK);
        chk("ch0 high clocks", e0, hi0);
        chk("ch1 high clocks", e1, hi1);
    endtask : window
    task automatic t_fields();
        rdc("ctl0 reset", OFS_PULSE_CONTROL, 8'h00);
        rdc("period reset", OFS_PERIOD, PERIOD_RESET);
        bus(1'b1, OFS_DUTY_HIGH, 8'hA5);
        bus(1'b1, OFS_DUTY_LOW, 8'hFF);
        bus(1'b1, OFS_DUTY_HIGH + CHANNEL_STRIDE, 8'h3C);
        bus(1'b1, OFS_DUTY_LOW + CHANNEL_STRIDE, 8'h40);
        bus(1'b1, OFS_PULSE_CONTROL, 8'h7F);
        repeat (6) @(posedge REF_CLK);
        rdc("ctl0 idle low", OFS_PULSE_CONTROL, 8'h30);
        rdc("ctl1 untouched", OFS_PULSE_CONTROL + CHANNEL_STRIDE, 8'h00);
        rdc("duty0 high", OFS_DUTY_HIGH, 8'hA5);
        rdc("duty0 low", OFS_DUTY_LOW, 8'hC0);
        rdc("duty1 high", OFS_DUTY_HIGH + CHANNEL_STRIDE, 8'h3C);
        bus(1'b1, 8'h0C, 8'hFF);
        rdc("unmapped", 8'h0C, 8'h00);
        @(posedge REF_CLK);
        RESET <= 1'b1;
        repeat (2) @(posedge REF_CLK);
        RESET <= 1'b0;
        rdc("ctl0 after reset", OFS_PULSE_CONTROL, 8'h00);
        rdc("duty0 kept", OFS_DUTY_HIGH, 8'hA5);
        rdc("duty1 low kept", OFS_DUTY_LOW + CHANNEL_STRIDE, 8'h40);
    endtask : t_fields
    task automatic t_run();
        bus(1'b1, OFS_PERIOD, 8'h00);
        rdc("period", OFS_PERIOD, 8'h00);
        bus(1'b1, OFS_DUTY_HIGH, 8'h00);
        bus(1'b1, OFS_DUTY_LOW, 8'h80);
        bus(1'b1, OFS_DUTY_HIGH + CHANNEL_STRIDE, 8'h00);
        bus(1'b1, OFS_PULSE_CONTROL, 8'h80);
        bus(1'b1, OFS_PULSE_CONTROL + CHANNEL_STRIDE, 8'h90);
        bus(1'b1, OFS_TIMER_CONTROL, 8'h01);
        window(8'h20, 8'h30);
        bus(1'b1, OFS_DUTY_LOW, 8'hC0);
        window(8'h30, 8'h30);
        bus(1'b1, OFS_DUTY_LOW + CHANNEL_STRIDE, 8'h00);
        window(8'h30, 8'h40);
        // Codes 2 and 3 both divide by 16, so both are run
        for (int c = 1; c < 4; c++) begin
            bus(1'b1, OFS_TIMER_CONTROL, {2'b00, 2'(c), 4'h1});
            window(8'h30, 8'h40);
        end
        rdc("timer control", OFS_TIMER_CONTROL, 8'h31);
        rdc("timer count", OFS_TIMER_COUNT, 8'h00);
        rdc("ctl1 live level", OFS_PULSE_CONTROL + CHANNEL_STRIDE, 8'hB0);
        bus(1'b1, OFS_PULSE_CONTROL, 8'h00);
        window(8'h00, 8'h40);
    endtask : t_run
    // Cuts a hang short
    always @(posedge REF_CLK) begin
        cycles++;
        if (cycles == 6000) begin
            miscompares++;
            print_verdict();
        end
    end
    initial begin
        repeat (2) @(posedge REF_CLK);
        RESET <= 1'b0;
        t_fields();
        t_run();
        print_verdict();
    end
endmodule : tb
bind pulse_width_control_regs pwm_chk i_chk (.REF_CLK(REF_CLK), .RESET(RESET),
    .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
    .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
    .PWM_OUT(PWM_OUT));
